// ==== hw/sbt_top.sv ====
// Register access over Wishbone is this design's own decision.
`timescale 1ns/100ps
module sbt_top
    import sbt_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_DIV
) (
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [31:0] i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic      [31:0] o_wb_dat,
    output logic             o_wb_ack,
    output logic             o_irq
);

    localparam int unsigned DIV_W = $clog2(TICK_CYCLES);

    // Hundredths steps must be 2 or 3 ticks apart; the count saturates
    localparam logic [2:0] GAP_ONE   = 3'h1;
    localparam logic [2:0] GAP_SHORT = 3'h2;
    localparam logic [2:0] GAP_LONG  = 3'h3;
    localparam logic [2:0] GAP_TOP   = 3'h7;

    logic [DIV_W-1:0] div_q;
    logic             tick_q;
    logic             ack_q;
    logic [7:0]       rd_q;
    logic             irq_q;
    sbt_run_t         state_q;
    sbt_run_t         state_d;
    logic [7:0]       pos_q;
    sbt_evt_t         flag_q;
    sbt_evt_t         en_q;
    sbt_evt_t         ev;
    sbt_evt_t         clr_mask;
    logic [3:0]       hund_dig;
    logic [3:0]       tenth_dig;
    logic             req;
    logic             wr;
    logic [29:0]      widx;
    logic             hit_ctl;
    logic             hit_cnt;
    logic             hit_msk;
    logic             hit_flg;
    logic             wr_ctl;
    logic             wr_msk;
    logic             wr_flg;
    logic [7:0]       wbyte;
    logic             run_wr1;
    logic             run_wr0;
    logic             clr;
    logic             cnt_en;
    logic             hund_inc;
    logic             ten_inc;
    logic             one_ev;
    logic             run_bit;
    logic [7:0]       rd_d;
    logic             acc;
    logic [2:0]       gap_q;

    // 256 Hz falling edge as a one-cycle enable
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else if (div_q == DIV_W'(TICK_CYCLES - 1)) begin
            div_q  <= '0;
            tick_q <= 1'b1;
        end else begin
            div_q  <= div_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    // Bus decode: read data latched when taken, acked one cycle later
    // Writes land on the edge that sees ack, where the master expects them
    assign acc   = i_wb_cyc & i_wb_stb;
    assign req   = acc & ~ack_q;
    assign wr    = acc & ack_q & i_wb_we & i_wb_sel[0];
    assign widx  = i_wb_adr[31:2];
    assign wbyte = i_wb_dat[7:0];

    assign hit_ctl = (widx == {14'h0000, IDX_CTL});
    assign hit_cnt = (widx == {14'h0000, IDX_CNT});
    assign hit_msk = (widx == {14'h0000, IDX_MSK});
    assign hit_flg = (widx == {14'h0000, IDX_FLG});

    assign wr_ctl = wr & hit_ctl;
    assign wr_msk = wr & hit_msk;
    assign wr_flg = wr & hit_flg;

    // Reserved bits are simply not stored
    assign run_wr1 = wr_ctl & wbyte[CTL_RUN_BIT];
    assign run_wr0 = wr_ctl & ~wbyte[CTL_RUN_BIT];
    assign clr     = wr_ctl & wbyte[CTL_CLR_BIT];

    // Run requests wait for the next 256 Hz edge
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (run_wr1) begin
                    state_d = ST_ARM;
                end
            end
            ST_ARM: begin
                if (run_wr0) begin
                    state_d = ST_IDLE;
                end else if (tick_q) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (run_wr0) begin
                    state_d = ST_HALT;
                end
            end
            ST_HALT: begin
                if (run_wr1) begin
                    state_d = ST_RUN;
                end else if (tick_q) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // A pending stop still counts on its tick: the extra +1
    assign cnt_en = tick_q & ((state_q == ST_RUN) | (state_q == ST_HALT));
    assign run_bit = (state_q != ST_IDLE);

    // Position within the second; wraps at 256 ticks
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            pos_q <= RST_BYTE;
        end else if (clr) begin
            pos_q <= RST_BYTE;
        end else if (cnt_en) begin
            pos_q <= pos_q + 8'h01;
        end
    end

    // Hundredths step where floor(pos*100/256) moves: gaps of 2 or 3
    function automatic logic sub_step(input logic [7:0] p);
        logic [15:0] now_v;
        logic [15:0] nxt_v;
        now_v = 16'(p) * SUBS_PER_SEC;
        nxt_v = (16'(p) + 16'h0001) * SUBS_PER_SEC;
        sub_step = (now_v[15:8] != nxt_v[15:8]);
    endfunction

    // Clear with run restarts from zero on the following ticks
    assign hund_inc = cnt_en & ~clr & sub_step(pos_q);

    // Ticks since the last hundredths step, kept only to check the pattern
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            gap_q <= GAP_ONE;
        end else if (clr | hund_inc) begin
            gap_q <= GAP_ONE;
        end else if (cnt_en && (gap_q != GAP_TOP)) begin
            gap_q <= gap_q + GAP_ONE;
        end
    end

    sbt_bcd_digit #(
        .MAX_VAL (BCD_MAX)
    ) u_hund (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_clr    (clr),
        .i_inc    (hund_inc),
        .o_digit  (hund_dig),
        .o_wrap   (ten_inc)
    );

    // Tenths pace 25 or 26 ticks in 4:6 mix, so 1 Hz is exact
    sbt_bcd_digit #(
        .MAX_VAL (BCD_MAX)
    ) u_tenth (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_clr    (clr),
        .i_inc    (ten_inc),
        .o_digit  (tenth_dig),
        .o_wrap   (one_ev)
    );

    assign ev.hundred_hz = hund_inc;
    assign ev.ten_hz     = ten_inc;
    assign ev.one_hz     = one_ev;

    // Write-1-to-clear; a new event in the same cycle wins
    assign clr_mask = wr_flg ? sbt_evt_t'(wbyte[EVT_W-1:0]) : '0;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            flag_q <= '0;
        end else begin
            flag_q <= (flag_q & ~clr_mask) | ev;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            en_q <= '0;
        end else if (wr_msk) begin
            en_q <= sbt_evt_t'(wbyte[EVT_W-1:0]);
        end
    end

    // One shared request line; lags the flags by one cycle
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(flag_q & en_q);
        end
    end

    // Counter is read live; software double-reads to filter a carry
    always_comb begin
        rd_d = RST_BYTE;
        if (hit_ctl) begin
            rd_d[CTL_RUN_BIT] = run_bit;
        end else if (hit_cnt) begin
            rd_d = {tenth_dig, hund_dig};
        end else if (hit_msk) begin
            rd_d[EVT_W-1:0] = en_q;
        end else if (hit_flg) begin
            rd_d[EVT_W-1:0] = flag_q;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ack_q <= 1'b0;
            rd_q  <= RST_BYTE;
        end else begin
            ack_q <= req;
            if (req) begin
                rd_q <= rd_d;
            end
        end
    end

    assign o_wb_ack = ack_q;
    assign o_wb_dat = {24'h000000, rd_q};
    assign o_irq    = irq_q;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    sequence s_stop_req;
        (state_q == ST_RUN) ##1 (state_q == ST_HALT);
    endsequence

    sequence s_last_tick;
        (state_q == ST_HALT) && tick_q && !wr_ctl;
    endsequence

    sequence s_stop_done;
        cnt_en ##1 (state_q == ST_IDLE);
    endsequence

    sequence s_arm_tick;
        (state_q == ST_ARM) && tick_q && !wr_ctl;
    endsequence

    irq_shared_a: assert property (
        |(flag_q & en_q) |=> o_irq
    ) else $error("shared request missing");

    flag_set_a: assert property (
        (ev != 3'b000) |=> ((flag_q & $past(ev)) == $past(ev))
    ) else $error("event did not set flag");

    irq_gate_a: assert property (
        ((flag_q & en_q) == 3'b000) |=> !o_irq
    ) else $error("request without enabled flag");

    clear_zero_a: assert property (
        clr |=> (hund_dig == BCD_ZERO && tenth_dig == BCD_ZERO)
    ) else $error("clear did not zero digits");

    stop_hold_a: assert property (
        (state_q == ST_IDLE && !clr) |=> $stable({tenth_dig, hund_dig})
    ) else $error("counter moved while stopped");

    digit_range_a: assert property (
        hund_dig <= BCD_MAX && tenth_dig <= BCD_MAX
    ) else $error("digit out of range");

    mask_write_a: assert property (
        wr_msk |=> (en_q == $past(wbyte[2:0]))
    ) else $error("mask write lost");

    flag_w1c_a: assert property (
        (wr_flg && wbyte[0] && !ev.hundred_hz) |=> !flag_q.hundred_hz
    ) else $error("flag not cleared by write");

    stop_last_count_a: assert property (
        s_last_tick |-> s_stop_done
    ) else $error("stop did not take one more count");

    carry_chain_a: assert property (
        (hund_inc && hund_dig == BCD_MAX && tenth_dig != BCD_MAX) |=>
            (hund_dig == BCD_ZERO && tenth_dig == $past(tenth_dig) + 4'h1)
    ) else $error("carry into tenths wrong");

    ack_pulse_a: assert property (
        o_wb_ack |=> !o_wb_ack
    ) else $error("ack held two cycles");

    ack_timing_a: assert property (
        (i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack
    ) else $error("request not acked next cycle");

    stop_reads_run_a: assert property (
        s_stop_req |-> run_bit
    ) else $error("run bit dropped before stop");

    run_start_a: assert property (
        s_arm_tick |-> !cnt_en ##1 (state_q == ST_RUN)
    ) else $error("run did not start on tick");

    ctl_read_a: assert property (
        (req && hit_ctl) |=> (rd_q[CTL_CLR_BIT] == 1'b0)
    ) else $error("clear bit read back as one");

    cnt_read_a: assert property (
        (req && hit_cnt) |=> (rd_q == {$past(tenth_dig), $past(hund_dig)})
    ) else $error("counter readout wrong");

    irq_masked_a: assert property (
        (en_q == 3'b000) |=> !o_irq
    ) else $error("request with all causes masked");

    tick_gap_a: assert property (
        hund_inc |-> (gap_q == GAP_SHORT || gap_q == GAP_LONG)
    ) else $error("hundredths step gap wrong");

endmodule

// ==== hw/sbt_pkg.sv ====
// Functional notes
// - All three interrupt causes share one request line; flags tell them apart.
// - Each 100 Hz, 10 Hz and 1 Hz falling edge sets its flag.
// - A cause requests an interrupt only while its enable bit is 1.
// - Control, counter, mask and flag registers sit at 0x5020 to 0x5023.
// - Writing 1 to control bit D4 clears both digits; it reads 0.
// - Clear while running resumes from zero; clear while stopped holds zero.
// - Control bit D0 runs (1) or stops (0); stopped counter holds.
// - Counter register: tenths in D7-4, hundredths in D3-0, read only.
// - Mask bits: 1 Hz at D2, 10 Hz at D1, 100 Hz at D0.
// - Flag bits at D2..D0 reset to 0 and clear on writing 1.
// - The 100 Hz tick comes from 256 Hz in two or three tick steps.
// - Hundredths make the 10 Hz signal at 4:6; tenths make 1 Hz.
// - Run/stop acts on the next 256 Hz edge; stop adds one count.
// - Run and clear written together clear first, then count.
package sbt_pkg;

    localparam int unsigned CLK_HZ   = 40_000_000;
    localparam int unsigned TICK_HZ  = 256;
    localparam int unsigned TICK_DIV = CLK_HZ / TICK_HZ;

    localparam logic [15:0] IDX_CTL = 16'h5020;
    localparam logic [15:0] IDX_CNT = 16'h5021;
    localparam logic [15:0] IDX_MSK = 16'h5022;
    localparam logic [15:0] IDX_FLG = 16'h5023;

    localparam int unsigned CTL_RUN_BIT = 0;
    localparam int unsigned CTL_CLR_BIT = 4;
    localparam int unsigned EVT_W       = 3;

    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic [3:0]  BCD_ZERO     = 4'h0;
    localparam logic [3:0]  BCD_MAX      = 4'h9;
    localparam logic [15:0] SUBS_PER_SEC = 16'h0064;

    typedef struct packed {
        logic one_hz;
        logic ten_hz;
        logic hundred_hz;
    } sbt_evt_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ARM  = 4'h2,
        ST_RUN  = 4'h4,
        ST_HALT = 4'h8
    } sbt_run_t;

endpackage

// ==== hw/sbt_bcd_digit.sv ====
`timescale 1ns/100ps
module sbt_bcd_digit
    import sbt_pkg::*;
#(
    parameter logic [3:0] MAX_VAL = BCD_MAX
) (
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_clr,
    input  wire logic       i_inc,
    output logic [3:0]      o_digit,
    output logic            o_wrap
);

    logic [3:0] dig_q;

    // Clear has priority so a count in the clear cycle is dropped
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            dig_q <= BCD_ZERO;
        end else if (i_clr) begin
            dig_q <= BCD_ZERO;
        end else if (i_inc) begin
            if (dig_q == MAX_VAL) begin
                dig_q <= BCD_ZERO;
            end else begin
                dig_q <= dig_q + 4'h1;
            end
        end
    end

    // Combinational carry lets both digits step on the same tick
    assign o_wrap  = i_inc & ~i_clr & (dig_q == MAX_VAL);
    assign o_digit = dig_q;

endmodule

// ==== bench/sbt_irq_model.sv ====
`timescale 1ns/100ps
module sbt_irq_model (
    input  wire logic       i_clk,
    input  wire logic       i_resetn,
    input  wire logic       i_irq,
    output logic      [7:0] o_req_cnt
);
    logic irq_q;

    // Level request: a line that stays high counts as one request only
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_q     <= 1'b0;
            o_req_cnt <= 8'h00;
        end else begin
            irq_q <= i_irq;
            if (i_irq && !irq_q) begin
                o_req_cnt <= o_req_cnt + 8'h01;
            end
        end
    end
endmodule

// ==== bench/sbt_top_test.sv ====
`timescale 1ns/100ps
module sbt_top_test
    import sbt_pkg::*;
;
    // Short tick keeps one stopwatch second at 4096 clocks
    localparam int unsigned TCK = 16;
    logic        i_clk    = 1'b0;
    logic        i_resetn = 1'b0;
    logic        cyc      = 1'b0;
    logic        stb      = 1'b0;
    logic        we       = 1'b0;
    logic [31:0] adr      = 32'h0;
    logic [3:0]  sel      = 4'h0;
    logic [31:0] wdat     = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic        irq;
    logic [7:0]  req_cnt;
    logic [7:0]  v;
    int          errors   = 0;
    int          checked  = 0;

    always #12.5 i_clk = ~i_clk;

    sbt_top #(.TICK_CYCLES(TCK)) u_sbt_top (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_wb_cyc (cyc),
        .i_wb_stb (stb),
        .i_wb_we  (we),
        .i_wb_adr (adr),
        .i_wb_sel (sel),
        .i_wb_dat (wdat),
        .o_wb_dat (rdat),
        .o_wb_ack (ack),
        .o_irq    (irq)
    );

    sbt_irq_model u_sbt_irq_model (
        .i_clk     (i_clk),
        .i_resetn  (i_resetn),
        .i_irq     (irq),
        .o_req_cnt (req_cnt)
    );

    task automatic wb(input logic w_en, input logic [15:0] idx,
                      input logic [7:0] d, input logic [3:0] s,
                      output logic [7:0] q);
        int n = 0;
        @(posedge i_clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w_en;
        adr  <= {14'h0, idx, 2'b00};
        sel  <= s;
        wdat <= {24'h0, d};
        do begin
            @(posedge i_clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        if (n >= 50) begin
            $display("BAD ack exp 1 got %b", ack);
            errors++;
        end
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, idx, d, 4'h1, q);
    endtask

    task automatic rd(input logic [15:0] idx, output logic [7:0] q);
        wb(1'b0, idx, 8'h00, 4'h1, q);
    endtask

    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        checked++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", nm, e, g);
            errors++;
        end
    endtask

    task automatic rchk(input string nm, input logic [15:0] idx,
                        input logic [7:0] e);
        logic [7:0] q;
        rd(idx, q);
        chk(nm, e, q);
    endtask

    // A running count may step between reads, so retry until two agree
    task automatic rd2(output logic [7:0] q);
        logic [7:0] a;
        logic [7:0] b;
        for (int k = 0; k < 5; k++) begin
            rd(IDX_CNT, a);
            rd(IDX_CNT, b);
            if (a === b) break;
        end
        q = b;
    endtask

    task automatic ticks(input int n);
        repeat (n * TCK) @(posedge i_clk);
    endtask

    function automatic logic [7:0] inr(logic [7:0] x, int lo, int hi);
        int t;
        t = x[7:4] * 10 + x[3:0];
        return {7'h0, (t >= lo && t <= hi && x[7:4] <= 9 && x[3:0] <= 9)};
    endfunction

    task automatic test_done;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_clk);
        $display("BAD watchdog exp done got timeout");
        errors++;
        test_done;
    end

    initial begin
        repeat (12) @(posedge i_clk);
        i_resetn <= 1'b1;
        rchk("ctl", IDX_CTL, RST_BYTE);
        rchk("cnt", IDX_CNT, RST_BYTE);
        rchk("msk", IDX_MSK, RST_BYTE);
        rchk("flg", IDX_FLG, RST_BYTE);
        wr(IDX_MSK, 8'h07);
        rchk("msk_rw", IDX_MSK, 8'h07);
        wb(1'b1, IDX_MSK, 8'h00, 4'h0, v);
        rchk("msk_sel", IDX_MSK, 8'h07);
        wr(IDX_MSK, 8'h00);
        wr(IDX_CNT, 8'h55);
        rchk("cnt_ro", IDX_CNT, 8'h00);
        wr(IDX_FLG + 16'h1, 8'h07);
        rchk("unmapped", IDX_FLG + 16'h1, 8'h00);
        wr(IDX_CTL, 8'h11);
        ticks(40);
        wr(IDX_CTL, 8'h11);
        rd(IDX_CNT, v);
        chk("clr_run", 8'h01, inr(v, 0, 1));
        ticks(128);
        rd2(v);
        chk("half_sec", 8'h01, inr(v, 48, 52));
        rchk("ctl_run", IDX_CTL, 8'h01);
        ticks(142);
        wr(IDX_CTL, 8'h00);
        ticks(3);
        rchk("ctl_stop", IDX_CTL, 8'h00);
        rd(IDX_CNT, v);
        ticks(10);
        rchk("cnt_hold", IDX_CNT, v);
        chk("wrap", 8'h01, inr(v, 3, 8));
        rchk("flg_all", IDX_FLG, 8'h07);
        chk("irq_off", 8'h00, {7'h0, irq});
        wr(IDX_FLG, 8'h00);
        rchk("flg_w0", IDX_FLG, 8'h07);
        wr(IDX_MSK, 8'h02);
        repeat (3) @(posedge i_clk);
        chk("irq_on", 8'h01, {7'h0, irq});
        chk("req_one", 8'h01, req_cnt);
        wr(IDX_FLG, 8'h02);
        rchk("flg_w1c", IDX_FLG, 8'h05);
        repeat (3) @(posedge i_clk);
        chk("irq_clr", 8'h00, {7'h0, irq});
        wr(IDX_MSK, 8'h04);
        repeat (3) @(posedge i_clk);
        chk("req_two", 8'h02, req_cnt);
        wr(IDX_FLG, 8'h05);
        rchk("flg_none", IDX_FLG, 8'h00);
        wr(IDX_CTL, 8'h10);
        rchk("clr_stop", IDX_CNT, 8'h00);
        ticks(5);
        rchk("clr_hold", IDX_CNT, 8'h00);
        rchk("ctl_clr", IDX_CTL, 8'h00);
        test_done;
    end
endmodule
